// File: tcso_regs.vh
// Register offsets, field positions, reset values and encodings of the option slice
`ifndef TCSO_REGS_VH
`define TCSO_REGS_VH

// Register addresses on the plain register port
`define TCSO_ADDR_W          4
`define TCSO_OFF_OPTION      4'h0
`define TCSO_OFF_TRIG_CFG    4'h1
`define TCSO_OFF_IRQ_STATUS  4'h2
`define TCSO_OFF_IRQ_ENABLE  4'h3
`define TCSO_OFF_IRQ_CLEAR   4'h4
`define TCSO_OFF_CORE_STATUS 4'h5

// Option register layout
`define TCSO_OPT_WRAP_BIT    0
`define TCSO_OPT_CCS_LO      4
`define TCSO_OPT_CCS_HI      7
`define TCSO_OPT_RESET       8'h00
`define TCSO_OPT_RW_MASK     8'hf1

// Trigger edge field encodings
`define TCSO_EDGE_NONE       2'h0
`define TCSO_EDGE_RISE       2'h1
`define TCSO_EDGE_FALL       2'h2
`define TCSO_EDGE_BOTH       2'h3

// Timer mode codes seen on the mode input
`define TCSO_MODE_FREE_RUN   3'h5
`define TCSO_MODE_PULSE_MEAS 3'h6

// Interrupt status bit positions
`define TCSO_IRQ_WRAP_BIT    0
`define TCSO_IRQ_TRIG_BIT    1

`endif

// File: tcso_edge_detect.v
// Synchroniser and selectable edge detector for the trigger input pin
`timescale 1ns/1ps
`include "tcso_regs.vh"
module tcso_edge_detect (
  input  wire       core_clk,
  input  wire       arst_n,
  input  wire       pin_in,
  input  wire [1:0] edge_sel,
  output reg        edge_pulse
);
  reg  [2:0] sync_q;
  reg        level_q;
  wire       rise;
  wire       fall;

  // Three stages; only stages two and three are compared
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sync_q  <= 3'h0;
      level_q <= 1'b0;
    end else begin
      sync_q <= {sync_q[1:0], pin_in};
      if (sync_q[1] == sync_q[2])
        level_q <= sync_q[2];
    end
  end

  assign rise = (sync_q[1] == sync_q[2]) && sync_q[2] && !level_q;
  assign fall = (sync_q[1] == sync_q[2]) && !sync_q[2] && level_q;

  // Edge choice per field code
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      edge_pulse <= 1'b0;
    end else begin
      case (edge_sel)
        `TCSO_EDGE_RISE: edge_pulse <= rise;
        `TCSO_EDGE_FALL: edge_pulse <= fall;
        `TCSO_EDGE_BOTH: edge_pulse <= rise | fall;
        default:         edge_pulse <= 1'b0;
      endcase
    end
  end
endmodule // tcso_edge_detect

// File: tcso_top.v
// Capture select, counter wrap flag and trigger edge select of the timer unit
//
// The placing of the registers and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
`include "tcso_regs.vh"

// Functional notes
// - 8-bit option register holds four capture selects and wrap flag, reset zero.
// - Option register takes whole-byte and single-bit reads and writes.
// - Select bit 0 means compare, 1 capture; only in free-running mode.
// - Wrap flag sets on counter wrap, only in free-running or pulse-measure.
// - Wrap flag clears on software write of 0 or count-run bit low.
// - Wrap interrupt rises in the same cycle the wrap flag sets.
// - No wrap interrupt in modes other than free-running and pulse-measure.
// - Reading the flag or register never clears the flag.
// - Software writing 1 to the wrap flag has no effect.
module tcso_top (
  input  wire                    core_clk,
  input  wire                    arst_n,
  input  wire [`TCSO_ADDR_W-1:0] reg_addr,
  input  wire [7:0]              reg_wdata,
  input  wire [7:0]              reg_wmask,
  input  wire                    reg_wr,
  input  wire                    reg_rd,
  output reg  [7:0]              reg_rdata,
  input  wire                    count_run_bit,
  input  wire [2:0]              timer_mode,
  input  wire                    counter_wrap,
  input  wire                    trigger_event_input,
  output reg  [3:0]              channel_capture_select,
  output reg                     counter_wrap_irq,
  output reg                     trigger_pulse,
  output reg                     irq
);
  // ********************************************************
  // Registers
  // ********************************************************
  reg  [3:0] ccs_q;
  reg        wrap_flag_q;
  reg  [1:0] trig_sel_q;
  reg  [1:0] event_sel_q;
  reg  [1:0] irq_stat_q;
  reg  [1:0] irq_en_q;
  reg  [7:0] opt_wr_d;
  wire       edge_pulse;
  wire       wrap_mode;
  wire       free_mode;
  wire       wrap_set;
  wire       opt_wr;
  wire       cfg_wr;
  wire       clr_wr;
  wire       en_wr;
  wire [7:0] opt_view;
  wire [7:0] cfg_wr_d;
  // Reset image of the option byte, kept at full width for slicing
  localparam [7:0] OPT_RST = `TCSO_OPT_RESET;

  // Masked merge: bits with mask 0 keep their value, so a one-bit
  // manipulation is a write with a single mask bit set
  function [7:0] merge;
    input [7:0] old_v;
    input [7:0] new_v;
    input [7:0] mask;
    begin
      merge = (old_v & ~mask) | (new_v & mask);
    end
  endfunction

  // ********************************************************
  // Decode
  // ********************************************************
  assign opt_wr = reg_wr && (reg_addr == `TCSO_OFF_OPTION);
  assign cfg_wr = reg_wr && (reg_addr == `TCSO_OFF_TRIG_CFG);
  assign clr_wr = reg_wr && (reg_addr == `TCSO_OFF_IRQ_CLEAR);
  assign en_wr  = reg_wr && (reg_addr == `TCSO_OFF_IRQ_ENABLE);

  assign free_mode = (timer_mode == `TCSO_MODE_FREE_RUN);
  assign wrap_mode = free_mode || (timer_mode == `TCSO_MODE_PULSE_MEAS);
  // Wrap counts only while running in the two allowed modes
  assign wrap_set  = counter_wrap && wrap_mode && count_run_bit;

  assign opt_view = {ccs_q, 3'h0, wrap_flag_q};

  // Merged option byte for a write
  always @* begin
    opt_wr_d = merge(opt_view, reg_wdata, reg_wmask & `TCSO_OPT_RW_MASK);
  end

  // ********************************************************
  // Option register
  // ********************************************************
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ccs_q       <= OPT_RST[`TCSO_OPT_CCS_HI:`TCSO_OPT_CCS_LO];
      wrap_flag_q <= 1'b0;
    end else begin
      if (opt_wr)
        ccs_q <= opt_wr_d[`TCSO_OPT_CCS_HI:`TCSO_OPT_CCS_LO];
      // Hardware set beats any clear; a 1 written never sets
      if (wrap_set)
        wrap_flag_q <= 1'b1;
      else if (!count_run_bit)
        wrap_flag_q <= 1'b0;
      else if (opt_wr && reg_wmask[`TCSO_OPT_WRAP_BIT] &&
               !reg_wdata[`TCSO_OPT_WRAP_BIT])
        wrap_flag_q <= 1'b0;
    end
  end

  // ********************************************************
  // Edge configuration
  // ********************************************************
  // Merged edge configuration byte; only the low nibble is stored
  assign cfg_wr_d = merge({4'h0, event_sel_q, trig_sel_q},
                          reg_wdata, reg_wmask);

  // Fields are taken as written; software keeps them still while running
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      trig_sel_q  <= `TCSO_EDGE_NONE;
      event_sel_q <= `TCSO_EDGE_NONE;
    end else if (cfg_wr) begin
      {event_sel_q, trig_sel_q} <= cfg_wr_d[3:0];
    end
  end

  tcso_edge_detect u_edge (
    .core_clk   (core_clk),
    .arst_n     (arst_n),
    .pin_in     (trigger_event_input),
    .edge_sel   (trig_sel_q),
    .edge_pulse (edge_pulse)
  );

  // ********************************************************
  // Interrupts and outputs
  // ********************************************************
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_stat_q <= 2'h0;
      irq_en_q   <= 2'h0;
    end else begin
      if (en_wr)
        irq_en_q <= reg_wdata[1:0];
      // Set wins over a clear in the same cycle
      irq_stat_q <= (irq_stat_q & ~(clr_wr ? reg_wdata[1:0] : 2'h0)) |
                    {edge_pulse, wrap_set};
    end
  end

  // Registered outputs
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      channel_capture_select <= 4'h0;
      counter_wrap_irq       <= 1'b0;
      trigger_pulse          <= 1'b0;
      irq                    <= 1'b0;
    end else begin
      // Capture selects act only in free-running mode
      channel_capture_select <= free_mode ? ccs_q : 4'h0;
      // Pulse one cycle after the wrap event, with the flag's rise
      counter_wrap_irq       <= wrap_set;
      trigger_pulse          <= edge_pulse;
      irq                    <= |(irq_stat_q & irq_en_q);
    end
  end

  // ********************************************************
  // Read port
  // ********************************************************
  // Reads have no side effect on any flag
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      if (reg_addr == `TCSO_OFF_OPTION)
        reg_rdata <= opt_view;
      else if (reg_addr == `TCSO_OFF_TRIG_CFG)
        reg_rdata <= {4'h0, event_sel_q, trig_sel_q};
      else if (reg_addr == `TCSO_OFF_IRQ_STATUS)
        reg_rdata <= {6'h00, irq_stat_q};
      else if (reg_addr == `TCSO_OFF_IRQ_ENABLE)
        reg_rdata <= {6'h00, irq_en_q};
      else if (reg_addr == `TCSO_OFF_CORE_STATUS)
        reg_rdata <= {3'h0, timer_mode, count_run_bit, wrap_flag_q};
      else
        reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= 8'h00;
    end
  end
endmodule // tcso_top

// File: tcso_props.sv
// Checker of wrap flag, capture select and read port
`timescale 1ns/1ps
module tcso_props (
  input wire       core_clk,
  input wire       arst_n,
  input wire [3:0] reg_addr,
  input wire       reg_rd,
  input wire [7:0] reg_rdata,
  input wire       count_run_bit,
  input wire [2:0] timer_mode,
  input wire       counter_wrap,
  input wire [3:0] channel_capture_select,
  input wire       counter_wrap_irq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  // A wrap counts only while running in a measuring mode
  sequence s_wrap_counted;
    counter_wrap && count_run_bit && timer_mode inside {3'h5, 3'h6};
  endsequence
  sequence s_stopped_read;
    !count_run_bit ##1 (!count_run_bit && reg_rd && reg_addr == 4'h0);
  endsequence
  a_wrap_sets_irq: assert property (s_wrap_counted |=> counter_wrap_irq)
    else $error("wrap irq missing");
  a_irq_needs_wrap: assert property (counter_wrap_irq |->
    $past(counter_wrap) && $past(count_run_bit)) else $error("stray irq");
  a_irq_mode_gate: assert property (counter_wrap_irq |->
    $past(timer_mode) inside {3'h5, 3'h6}) else $error("irq in bad mode");
  a_irq_one_pulse: assert property (counter_wrap_irq && !counter_wrap
    |=> !counter_wrap_irq) else $error("irq too long");
  a_select_gated: assert property ((timer_mode != 3'h5) [*2]
    |-> channel_capture_select == 4'h0) else $error("select not gated");
  a_stop_clears: assert property (s_stopped_read |=> !reg_rdata[0])
    else $error("flag kept while stopped");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data without read");
  a_unmapped_zero: assert property ($past(reg_rd) &&
    $past(reg_addr) > 4'h5 |-> reg_rdata == 8'h00) else $error("unmapped");
endmodule // tcso_props

bind tcso_top tcso_props u_props (.core_clk(core_clk), .arst_n(arst_n),
  .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .count_run_bit(count_run_bit), .timer_mode(timer_mode),
  .counter_wrap(counter_wrap), .counter_wrap_irq(counter_wrap_irq),
  .channel_capture_select(channel_capture_select));

// File: tcso_pin_model.sv
// Trigger pin source: one high pulse per request
`timescale 1ns/1ps
module tcso_pin_model #(parameter int HOLD = 8) (
  input  wire  core_clk,
  input  wire  go,
  output logic pin
);
  initial pin = 1'b0;
  // Held long enough to pass the synchroniser on both edges
  always @(posedge core_clk) begin
    if (go) begin
      pin <= 1'b1;
      repeat (HOLD) @(posedge core_clk);
      pin <= 1'b0;
    end
  end
endmodule // tcso_pin_model

// File: test_timer_capture_select_overflow.sv
// Self-checking bench of the option slice
`timescale 1ns/1ps
module test_timer_capture_select_overflow;
  logic       core_clk = 0, arst_n = 0, reg_wr = 0, reg_rd = 0, run = 0;
  logic       wrap = 0, pin, go = 0, wirq, tpulse, irq;
  logic [3:0] reg_addr = 0, ccs;
  logic [7:0] wdata = 0, wmask = 0, rdata;
  logic [2:0] mode = 0;
  int         err_count = 0, compares = 0, cycles = 0, pulses;
  tcso_top dut (.core_clk(core_clk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(wdata), .reg_wmask(wmask), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(rdata), .count_run_bit(run), .timer_mode(mode),
    .counter_wrap(wrap), .trigger_event_input(pin),
    .channel_capture_select(ccs), .counter_wrap_irq(wirq),
    .trigger_pulse(tpulse), .irq(irq));
  tcso_pin_model u_pin (.core_clk(core_clk), .go(go), .pin(pin));
  always #2.5 core_clk = ~core_clk;
  // Cycle ceiling cuts a hang short; pulses counted for edge tests
  always @(posedge core_clk) begin
    cycles++;
    if (tpulse === 1'b1) pulses++;
    if (cycles == 5000) begin
      err_count++;
      results();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d, m);
    @(posedge core_clk);
    reg_wr <= 1;
    reg_addr <= a;
    wdata <= d;
    wmask <= m;
    @(posedge core_clk);
    reg_wr <= 0;
  endtask
  // Read data stand only in the cycle after the read edge
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    reg_rd <= 1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 0;
    #1 chk(rdata, exp);
  endtask
  task automatic wrap_pulse(input logic exp);
    @(posedge core_clk);
    wrap <= 1;
    @(posedge core_clk);
    wrap <= 0;
    #1 chk(wirq, exp);
  endtask
  task automatic t_option;
    rd(4'h0, 8'h00);
    wr(4'h0, 8'hff, 8'hff);
    rd(4'h0, 8'hf0);
    wr(4'h0, 8'h00, 8'h10);
    rd(4'h0, 8'he0);
    rd(4'hf, 8'h00);
    @(posedge core_clk) mode <= 3'h5;
    repeat (3) @(posedge core_clk);
    #1 chk(ccs, 4'he);
    @(posedge core_clk) mode <= 3'h6;
    repeat (3) @(posedge core_clk);
    #1 chk(ccs, 4'h0);
  endtask
  task automatic t_wrap;
    mode <= 3'h5;
    run <= 1;
    wr(4'h3, 8'h01, 8'hff);
    wrap_pulse(1);
    @(posedge core_clk) #1 chk(irq, 1);
    rd(4'h0, 8'he1);
    wr(4'h0, 8'h01, 8'h01);
    rd(4'h0, 8'he1);
    wr(4'h0, 8'h00, 8'h01);
    rd(4'h0, 8'he0);
    wr(4'h4, 8'h01, 8'hff);
    repeat (2) @(posedge core_clk) #1 chk(irq, 0);
    wr(4'h3, 8'h00, 8'hff);
    mode <= 3'h6;
    wrap_pulse(1);
    rd(4'h2, 8'h01);
    chk(irq, 0);
    @(posedge core_clk) run <= 0;
    rd(4'h0, 8'he0);
    @(posedge core_clk);
    mode <= 3'h2;
    run <= 1;
    wrap_pulse(0);
    rd(4'h0, 8'he0);
    run <= 0;
  endtask
  task automatic t_edges;
    logic [7:0] exp [4] = '{0, 1, 1, 2};
    for (int c = 0; c < 4; c++) begin
      wr(4'h1, c[7:0], 8'hff);
      pulses = 0;
      go <= 1;
      @(posedge core_clk) go <= 0;
      repeat (30) @(posedge core_clk);
      chk(pulses[7:0], exp[c]);
    end
    rd(4'h1, 8'h03);
    rd(4'h2, 8'h03);
    rd(4'h5, 8'h08);
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge core_clk);
    arst_n <= 1;
    t_option();
    t_wrap();
    t_edges();
    results();
  end
endmodule // test_timer_capture_select_overflow
